/* File: verilog/spindle_pkg.sv */
// Purpose: Shared constants and types for the spindle and coolant output control.
// Assumes: 50 MHz clock, 32-bit Avalon-MM register word per offset.
// Notes:   Timing counts derive from the clock rate; offsets are byte addresses.
`default_nettype none
package spindle_pkg;
    localparam int CLK_HZ      = 50_000_000;
    localparam int TICK_MS     = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    localparam int SPD_W = 16;
    localparam int DW    = 40;
    localparam int DAC_W = 12;
    // Full-scale 10V code and 1e6/pi (surface m/min over diameter in um)
    localparam logic [DW-1:0]    DAC_FULL_DW = 40'h0000000FFF;
    localparam logic [DAC_W-1:0] DAC_FULL    = 12'hFFF;
    localparam logic [DW-1:0]    CSS_SCALE   = 40'h000004DB66;
    localparam logic [2:0]       MAX_LINES   = 3'h4;

    localparam logic [7:0] A_CFG     = 8'h00;
    localparam logic [7:0] A_PULSE   = 8'h04;
    localparam logic [7:0] A_LINES   = 8'h08;
    localparam logic [7:0] A_GMAX1   = 8'h0C;
    localparam logic [7:0] A_GMAX2   = 8'h10;
    localparam logic [7:0] A_GMAX3   = 8'h14;
    localparam logic [7:0] A_GMAX4   = 8'h18;
    localparam logic [7:0] A_CSS_MIN = 8'h1C;
    localparam logic [7:0] A_CSS_MAX = 8'h20;
    localparam logic [7:0] A_BOUND   = 8'h24;
    localparam logic [7:0] A_FLUCT   = 8'h28;
    localparam logic [7:0] A_JOG_T   = 8'h2C;
    localparam logic [7:0] A_JOG_S   = 8'h30;
    localparam logic [7:0] A_CMD     = 8'h34;
    localparam logic [7:0] A_STAT    = 8'h38;
    localparam logic [7:0] A_SPEED   = 8'h3C;
    localparam logic [7:0] A_MEAS    = 8'h40;
    localparam logic [7:0] A_SURF    = 8'h44;
    localparam logic [7:0] A_DIAM    = 8'h48;
    localparam logic [7:0] A_CTRL    = 8'h4C;
    localparam logic [7:0] A_RESULT  = 8'h50;

    localparam int CFG_PULSE   = 7;
    localparam int CFG_CONV    = 6;
    localparam int CFG_CODED   = 5;
    localparam int CFG_AXIS    = 4;
    localparam int CFG_NOBRAKE = 3;
    localparam int CFG_NOCCW   = 2;
    localparam logic [7:0] CFG_MASK = 8'hFC;
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam int ST_REJ = 9;

    localparam logic [3:0] C_CW     = 4'h1;
    localparam logic [3:0] C_CCW    = 4'h2;
    localparam logic [3:0] C_STOP   = 4'h3;
    localparam logic [3:0] C_COOL1  = 4'h4;
    localparam logic [3:0] C_COOL0  = 4'h5;
    localparam logic [3:0] C_GEAR   = 4'h6;
    localparam logic [3:0] C_JOG    = 4'h7;
    localparam logic [3:0] C_THREAD = 4'h8;
    localparam logic [3:0] C_BLKEND = 4'h9;
    localparam logic [3:0] C_CYCLE  = 4'hA;
    localparam logic [3:0] C_AXIS1  = 4'hB;
    localparam logic [3:0] C_AXIS0  = 4'hC;

    localparam int O_CW = 0;
    localparam int O_CCW = 1;
    localparam int O_STOP = 2;
    localparam int O_COOL1 = 3;
    localparam int O_COOL0 = 4;
    localparam int O_BRK = 5;

    typedef struct packed {
        logic brake;
        logic cool_off;
        logic cool_on;
        logic stop;
        logic ccw;
        logic cw;
    } spindle_out_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_CSS  = 3'b010,
        S_DAC  = 3'b100
    } calc_state_t;
endpackage
`default_nettype wire

/* File: verilog/spindle_gear_output_control.sv */
// Purpose: Spindle run/stop/reverse, coolant, brake, gear select and speed scaling.
// Assumes: Software drives commands and measured speed through the register bus.
// Notes:   One divider is shared by surface-speed and analog scaling, so results lag.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module spindle_gear_output_control
    import spindle_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic               clock,
    input  wire logic               rst_b,
    input  wire logic [7:0]         address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [31:0]        writedata,
    output logic      [31:0]        readdata,
    output logic                    waitrequest,
    output spindle_out_t            spindle_out,
    output logic      [3:0]         gear_select_lines,
    output logic      [DAC_W-1:0]   analog_code,
    output logic                    thread_alarm
);
    logic [7:0]        cfg;
    logic [15:0]       pulse_ms, jog_ms, jog_spd, css_min, css_max, bound, fluct;
    logic [15:0]       target, meas, surf, css_rpm, ref_spd, jog_cnt;
    logic [15:0]       gmax [4];
    logic [15:0]       tmr [6];
    logic signed [31:0] diam;
    logic [2:0]        line_cnt, lines;
    logic [3:0]        gear, conv_gear;
    logic              ack, css_en, rejected, run_cw, run_ccw, cool, jog_active;
    logic              thread_active, thread_high, fluct_seen, paused, axis_mode, pend;
    logic [31:0]       tick_cnt;
    logic              tick;
    logic [5:0]        ev, act;
    calc_state_t       st;
    logic [DW-1:0]     quo, den_r, d_num, d_den;
    logic [DW:0]       rem, rem_sh;
    logic [5:0]        dcnt;
    logic              d_done, d_load;
    wire pulse_mode = cfg[CFG_PULSE];
    wire conv       = cfg[CFG_CONV];
    wire coded      = cfg[CFG_CODED];
    wire axis_ok    = cfg[CFG_AXIS];
    wire no_brake   = cfg[CFG_NOBRAKE];
    wire no_ccw     = cfg[CFG_NOCCW];
    // Bus: one wait cycle per access; readdata is captured during it
    assign waitrequest = (read | write) & ~ack;
    wire wr_ok = write & ack;
    always_ff @(posedge clock) begin
        if (!rst_b) ack <= 1'b0;
        else        ack <= (read | write) & ~ack;
    end
    wire       cmd  = wr_ok && address == A_CMD;
    wire [3:0] code = writedata[3:0];
    wire [3:0] arg  = writedata[7:4];
    wire       spd_wr = wr_ok && address == A_SPEED;
    // Only the low lines are usable; more than four are clipped
    assign lines = (line_cnt > MAX_LINES) ? MAX_LINES : line_cnt;
    function automatic logic gear_ok(input logic [3:0] g, input logic cd, input logic [2:0] n);
        if (cd) gear_ok = {1'b0, g} < (5'h01 << n);
        else    gear_ok = g <= {1'b0, n};
    endfunction
    wire jog_go   = cmd && code == C_JOG && jog_ms != 16'h0000 && !jog_active;
    wire jog_end  = jog_active && tick && jog_cnt == 16'h0001;
    wire gear_cmd = cmd && code == C_GEAR && conv && arg >= 4'h1 && arg <= 4'h4;
    wire spd_gear = spd_wr && !conv && writedata[15:4] == 12'h000
                    && gear_ok(writedata[3:0], coded, lines);
    wire axis_cmd = cmd && (code == C_AXIS1 || code == C_AXIS0);
    wire refuse = (cmd && code == C_CCW && no_ccw)
               || (cmd && code == C_GEAR && !gear_cmd)
               || (spd_wr && !conv && !spd_gear)
               || (axis_cmd && !axis_ok)
               || (cmd && code == C_JOG && jog_ms == 16'h0000);
    always_comb begin
        ev         = '0;
        ev[O_CW]   = (cmd && code == C_CW) || jog_go;
        ev[O_CCW]  = cmd && code == C_CCW && !no_ccw;
        ev[O_STOP] = (cmd && code == C_STOP) || jog_end;
        ev[O_COOL1] = cmd && code == C_COOL1;
        ev[O_COOL0] = cmd && code == C_COOL0;
        ev[O_BRK]  = ev[O_STOP] && !no_brake;
    end
    // Millisecond time base
    assign tick = tick_cnt == 32'(TICK_DIV - 1);
    always_ff @(posedge clock) begin
        if (!rst_b || tick) tick_cnt <= '0;
        else                tick_cnt <= tick_cnt + 32'h1;
    end
    // Registers written by software
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cfg <= CFG_RST; pulse_ms <= '0; line_cnt <= '0; css_min <= '0;
            css_max <= 16'hFFFF; bound <= '0; fluct <= '0; jog_ms <= '0;
            jog_spd <= '0; target <= '0; meas <= '0; surf <= '0; diam <= '0;
            css_en <= 1'b0;
            for (int i = 0; i < 4; i++) gmax[i] <= '0;
        end else if (wr_ok) begin
            case (address)
                A_CFG:     cfg <= writedata[7:0] & CFG_MASK;
                A_PULSE:   pulse_ms <= writedata[15:0];
                A_LINES:   line_cnt <= writedata[2:0];
                A_GMAX1:   gmax[0] <= writedata[15:0];
                A_GMAX2:   gmax[1] <= writedata[15:0];
                A_GMAX3:   gmax[2] <= writedata[15:0];
                A_GMAX4:   gmax[3] <= writedata[15:0];
                A_CSS_MIN: css_min <= writedata[15:0];
                A_CSS_MAX: css_max <= writedata[15:0];
                A_BOUND:   bound <= writedata[15:0];
                A_FLUCT:   fluct <= writedata[15:0];
                A_JOG_T:   jog_ms <= writedata[15:0];
                A_JOG_S:   jog_spd <= writedata[15:0];
                A_SPEED:   if (conv) target <= writedata[15:0];
                A_MEAS:    meas <= writedata[15:0];
                A_SURF:    surf <= writedata[15:0];
                A_DIAM:    diam <= writedata;
                A_CTRL:    css_en <= writedata[0];
                default:   ;
            endcase
        end
    end
    // Refused command flag; a new refusal wins over the write-one clear
    always_ff @(posedge clock) begin
        if (!rst_b) rejected <= 1'b0;
        else if (refuse) rejected <= 1'b1;
        else if (wr_ok && address == A_STAT && writedata[ST_REJ]) rejected <= 1'b0;
    end
    // Steady run and coolant states
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            run_cw <= 1'b0; run_ccw <= 1'b0; cool <= 1'b0;
        end else begin
            if (ev[O_CW]) begin
                run_cw <= 1'b1; run_ccw <= 1'b0;
            end else if (ev[O_CCW]) begin
                run_cw <= 1'b0; run_ccw <= 1'b1;
            end else if (ev[O_STOP]) begin
                run_cw <= 1'b0; run_ccw <= 1'b0;
            end
            if (ev[O_COOL1]) cool <= 1'b1;
            else if (ev[O_COOL0]) cool <= 1'b0;
        end
    end
    // Pulse timers, one per output line; width zero still gives one tick
    for (genvar i = 0; i < 6; i++) begin : g_tmr
        always_ff @(posedge clock) begin
            if (!rst_b) tmr[i] <= '0;
            else if (ev[i]) tmr[i] <= (pulse_ms == 16'h0000) ? 16'h0001 : pulse_ms;
            else if (tick && tmr[i] != 16'h0000) tmr[i] <= tmr[i] - 16'h0001;
        end
        assign act[i] = tmr[i] != 16'h0000;
    end
    always_ff @(posedge clock) begin
        if (!rst_b) spindle_out <= '0;
        else begin
            spindle_out.cw       <= pulse_mode ? act[O_CW] : run_cw;
            spindle_out.ccw      <= !no_ccw && (pulse_mode ? act[O_CCW] : run_ccw);
            spindle_out.stop     <= pulse_mode ? act[O_STOP] : !(run_cw || run_ccw);
            spindle_out.cool_on  <= pulse_mode ? act[O_COOL1] : cool;
            spindle_out.cool_off <= pulse_mode && act[O_COOL0];
            spindle_out.brake    <= !no_brake && act[O_BRK];
        end
    end
    // Gear selection and encoding onto the enabled lines
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            gear <= '0; conv_gear <= 4'h1;
        end else if (gear_cmd) begin
            gear <= arg; conv_gear <= arg;
        end else if (spd_gear) begin
            gear <= writedata[3:0];
        end
    end
    wire [3:0] line_mask = 4'((5'h01 << lines) - 5'h01);
    wire [3:0] one_hot   = (gear == 4'h0) ? 4'h0 : 4'((5'h01 << gear) >> 1);
    always_ff @(posedge clock) begin
        if (!rst_b) gear_select_lines <= '0;
        else gear_select_lines <= (coded ? gear : one_hot) & line_mask;
    end
    // Spindle/axis switching
    always_ff @(posedge clock) begin
        if (!rst_b) axis_mode <= 1'b0;
        else if (axis_cmd && axis_ok) axis_mode <= code == C_AXIS1;
    end
    // Jog timing
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            jog_active <= 1'b0; jog_cnt <= '0;
        end else if (jog_go) begin
            jog_active <= 1'b1; jog_cnt <= jog_ms;
        end else if (jog_end || (cmd && code == C_STOP)) begin
            jog_active <= 1'b0; jog_cnt <= '0;
        end else if (jog_active && tick) begin
            jog_cnt <= jog_cnt - 16'h0001;
        end
    end
    // Thread mode and fluctuation alarm
    wire [15:0] dev = (meas > ref_spd) ? meas - ref_spd : ref_spd - meas;
    wire fluct_now  = thread_active && dev > fluct;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            thread_active <= 1'b0; thread_high <= 1'b0; ref_spd <= '0;
            fluct_seen <= 1'b0; paused <= 1'b0; thread_alarm <= 1'b0;
        end else if (cmd && code == C_THREAD) begin
            thread_active <= 1'b1; ref_spd <= meas; fluct_seen <= 1'b0;
            thread_high <= meas > bound;
        end else if (cmd && code == C_BLKEND) begin
            thread_active <= 1'b0; fluct_seen <= 1'b0;
            if (fluct_seen || fluct_now) begin
                paused <= 1'b1; thread_alarm <= 1'b1;
            end
        end else if (cmd && code == C_CYCLE) begin
            paused <= 1'b0; thread_alarm <= 1'b0;
        end else if (fluct_now) begin
            fluct_seen <= 1'b1;
        end
    end
    // Speed source and scaling
    wire        jog_own = jog_active && jog_spd != 16'h0000;
    wire [15:0] jog_src = jog_own ? jog_spd : target;
    wire        use_css = css_en && !jog_own;
    wire [15:0] q_sat   = (|quo[DW-1:16]) ? 16'hFFFF : quo[15:0];
    wire [15:0] clamped = (q_sat < css_min) ? css_min
                        : (q_sat > css_max) ? css_max : q_sat;
    wire [15:0] src     = (st == S_CSS) ? clamped : (use_css ? css_rpm : jog_src);
    wire [1:0]  gidx    = (conv_gear == 4'h0) ? 2'h0 : 2'(conv_gear - 4'h1);
    wire [15:0] gm      = gmax[gidx];
    wire [15:0] lim     = (src > gm) ? gm : src;
    wire [31:0] dabs    = diam[31] ? 32'(-diam) : diam;
    wire kick = conv && ((wr_ok && (address == A_SPEED || address == A_SURF ||
                address == A_DIAM || address == A_CTRL || address == A_CSS_MIN ||
                address == A_CSS_MAX || address == A_JOG_S || address[7:4] == 4'h1 ||
                address == A_GMAX1)) || gear_cmd || jog_go || jog_end);
    always_comb begin
        d_load = 1'b0;
        d_num  = {24'h0, lim} * DAC_FULL_DW;
        d_den  = {24'h0, gm};
        if (st == S_IDLE && pend && conv) begin
            d_load = 1'b1;
            if (use_css) begin
                d_num = {24'h0, surf} * CSS_SCALE;
                d_den = {8'h0, dabs};
            end
        end else if (st == S_CSS && d_done) begin
            d_load = 1'b1;
        end
    end
    // Restoring divider; zero divisor saturates, which the clamps absorb
    assign rem_sh = {rem[DW-1:0], quo[DW-1]};
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            quo <= '0; rem <= '0; den_r <= '0; dcnt <= '0; d_done <= 1'b0;
        end else begin
            d_done <= dcnt == 6'h01;
            if (d_load) begin
                quo <= d_num; rem <= '0; den_r <= d_den; dcnt <= 6'(DW);
            end else if (dcnt != 6'h00) begin
                dcnt <= dcnt - 6'h01;
                if (rem_sh >= {1'b0, den_r}) begin
                    rem <= rem_sh - {1'b0, den_r};
                    quo <= {quo[DW-2:0], 1'b1};
                end else begin
                    rem <= rem_sh;
                    quo <= {quo[DW-2:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) pend <= 1'b0;
        else pend <= kick || (pend && !(st == S_IDLE));
    end
    always_ff @(posedge clock) begin
        if (!rst_b) st <= S_IDLE;
        else begin
            case (st)
                S_IDLE: if (d_load) st <= use_css ? S_CSS : S_DAC;
                S_CSS:  if (d_done) st <= S_DAC;
                S_DAC:  if (d_done) st <= S_IDLE;
                default: st <= S_IDLE;
            endcase
        end
    end
    // Analog code holds zero unless a converter drives the spindle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            css_rpm <= '0; analog_code <= '0;
        end else begin
            if (st == S_CSS && d_done) css_rpm <= clamped;
            if (!conv) analog_code <= '0;
            else if (st == S_DAC && d_done)
                analog_code <= (|quo[DW-1:DAC_W]) ? DAC_FULL : quo[DAC_W-1:0];
        end
    end

    // Read path
    always_ff @(posedge clock) begin
        if (!rst_b) readdata <= '0;
        else if (read && !ack) begin
            case (address)
                A_CFG:     readdata <= {24'h0, cfg};
                A_PULSE:   readdata <= {16'h0, pulse_ms};
                A_LINES:   readdata <= {29'h0, line_cnt};
                A_GMAX1:   readdata <= {16'h0, gmax[0]};
                A_GMAX2:   readdata <= {16'h0, gmax[1]};
                A_GMAX3:   readdata <= {16'h0, gmax[2]};
                A_GMAX4:   readdata <= {16'h0, gmax[3]};
                A_CSS_MIN: readdata <= {16'h0, css_min};
                A_CSS_MAX: readdata <= {16'h0, css_max};
                A_BOUND:   readdata <= {16'h0, bound};
                A_FLUCT:   readdata <= {16'h0, fluct};
                A_JOG_T:   readdata <= {16'h0, jog_ms};
                A_JOG_S:   readdata <= {16'h0, jog_spd};
                A_STAT:    readdata <= {16'h0, gear, 1'b0, st != S_IDLE, rejected,
                                        axis_mode, jog_active, paused, thread_alarm,
                                        thread_active, thread_high, cool, run_ccw, run_cw};
                A_SPEED:   readdata <= {16'h0, target};
                A_MEAS:    readdata <= {16'h0, meas};
                A_SURF:    readdata <= {16'h0, surf};
                A_DIAM:    readdata <= diam;
                A_CTRL:    readdata <= {31'h0, css_en};
                A_RESULT:  readdata <= {4'h0, analog_code, css_rpm};
                default:   readdata <= '0;
            endcase
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_brake_path;
        ##1 act[O_BRK] ##1 spindle_out.brake;
    endsequence
    property p_brake_on;
        ev[O_STOP] && !no_brake |-> s_brake_path;
    endproperty
    a_brake_on: assert property (p_brake_on) else $error("brake not raised on stop");
    property p_brake_off;
        no_brake && $past(no_brake) |-> !spindle_out.brake;
    endproperty
    a_brake_off: assert property (p_brake_off) else $error("brake raised while unused");
    property p_no_ccw;
        no_ccw && $past(no_ccw) |-> !spindle_out.ccw;
    endproperty
    a_no_ccw: assert property (p_no_ccw) else $error("reverse driven while unused");
    property p_gear_refused;
        cmd && code == C_GEAR && !conv |=> rejected && $stable(gear);
    endproperty
    a_gear_refused: assert property (p_gear_refused) else $error("gear cmd taken in gear-shift mode");
    property p_lines;
        $stable(line_cnt) |-> (gear_select_lines & ~line_mask) == 4'h0;
    endproperty
    a_lines: assert property (p_lines) else $error("select line above count driven");
    property p_thread_mode;
        cmd && code == C_THREAD |=> thread_high == ($past(meas) > $past(bound));
    endproperty
    a_thread_mode: assert property (p_thread_mode) else $error("thread mode wrong");
    property p_fluct;
        cmd && code == C_BLKEND && fluct_seen |=> paused && thread_alarm;
    endproperty
    a_fluct: assert property (p_fluct) else $error("fluctuation alarm missing");
    property p_jog_zero;
        cmd && code == C_JOG && jog_ms == 16'h0000 && !jog_active |=> !jog_active ##1 !spindle_out.cw || run_cw;
    endproperty
    a_jog_zero: assert property (p_jog_zero) else $error("jog ran with zero time");
    property p_css_clamp;
        st == S_CSS && d_done && css_min <= css_max |=> css_rpm >= css_min && css_rpm <= css_max;
    endproperty
    a_css_clamp: assert property (p_css_clamp) else $error("surface speed out of limits");
    property p_tick;
        tick |=> !tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick longer than a cycle");
endmodule
`default_nettype wire

/* File: verif/spindle_far_side.sv */
// Purpose: Far-side relay model that times the brake coil.
// Assumes: Brake relay is a plain active-high coil.
// Notes:   Width is kept in clocks; the bench checks it in clocks as well.
`timescale 1ns/1ps
`default_nettype none
module spindle_far_side
    import spindle_pkg::*;
(
    input  wire logic         clock,
    input  wire spindle_out_t spindle_out,
    output var  int           brake_len
);
    int run = 0;
    always @(posedge clock) begin
        run <= spindle_out.brake ? run + 1 : 0;
        if (!spindle_out.brake && run != 0) brake_len <= run;
    end
endmodule
`default_nettype wire

/* File: verif/spindle_gear_output_control_tb_top.sv */
// Purpose: Self-checking bench for the spindle output control.
// Assumes: TICK_DIV of 10 so one ms is ten clocks.
// Notes:   Reads are scored through a queue by a separate monitor.
`timescale 1ns/1ps
`default_nettype none
module spindle_gear_output_control_tb_top
    import spindle_pkg::*;
;
    logic         clock = 0, rst_b = 0, read = 0, write = 0, waitrequest, thread_alarm;
    logic [7:0]   address = 0;
    logic [31:0]  writedata = 0, readdata;
    logic [3:0]   gear_select_lines;
    logic [11:0]  analog_code;
    logic [63:0]  expq[$];
    spindle_out_t spindle_out;
    int           err_count = 0, n_checks = 0, cyc = 0, brake_len;
    logic [15:0]  r;
    spindle_gear_output_control #(.TICK_DIV(10)) i_spindle_gear_output_control (.clock(clock), .rst_b(rst_b),
        .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .spindle_out(spindle_out), .gear_select_lines(gear_select_lines),
        .analog_code(analog_code), .thread_alarm(thread_alarm));
    spindle_far_side i_spindle_far_side (.clock(clock), .spindle_out(spindle_out), .brake_len(brake_len));
    initial forever #10 clock = ~clock;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Request held until waitrequest is seen low, released only after that edge
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a; read <= !w; write <= w; writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        read <= 0; write <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        expq.push_back({m, e});
        acc(0, a, 0);
    endtask
    task settle;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    // Read data is taken at the very edge where waitrequest is sampled low
    always @(posedge clock) begin
        if (read && waitrequest === 1'b0) begin
            chk(readdata & expq[0][63:32], expq[0][31:0]);
            void'(expq.pop_front());
        end
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up;
        end
    end
    logic [7:0]  ra[4] = '{A_SPEED, A_CMD, A_CMD, A_CMD};
    logic [31:0] rv[4] = '{3, 32'h16, 32'hB, 32'h7};
    initial begin
        void'($urandom(32'h81f614c9));
        repeat (20) @(posedge clock);
        rst_b <= 1;
        rd(A_CFG, '1, 0); rd(A_CSS_MAX, '1, 32'hFFFF); rd(8'h7C, '1, 0);
        r = 16'($urandom());
        acc(1, A_BOUND, {16'h0, r}); rd(A_BOUND, '1, {16'h0, r});
        $display("test registers done");
        acc(1, A_LINES, 2); acc(1, A_SPEED, 2); settle;
        chk(gear_select_lines, 4'h2);
        // Speed 3 over two lines, gear cmd, axis cmd and zero-length jog all refused
        for (int i = 0; i < 4; i++) begin
            acc(1, A_STAT, 32'h200); acc(1, ra[i], rv[i]);
            rd(A_STAT, 32'h200, 32'h200);
        end
        settle; chk(gear_select_lines, 4'h2);
        acc(1, A_CFG, 8'h20); acc(1, A_SPEED, 3); settle;
        chk(gear_select_lines, 4'h3);
        $display("test gears done");
        acc(1, A_CFG, 8'h04); acc(1, A_PULSE, 3); acc(1, A_CMD, C_CCW); settle;
        chk(spindle_out.ccw, 0);
        acc(1, A_CMD, C_CW); settle;
        chk(spindle_out.cw, 1);
        acc(1, A_CMD, C_STOP); settle;
        chk({spindle_out.stop, spindle_out.cw}, 2'b10);
        repeat (50) @(posedge clock);
        chk(brake_len >= 20 && brake_len <= 32, 1);
        $display("test outputs done");
        acc(1, A_CFG, 8'h80); acc(1, A_CMD, C_COOL1); settle;
        chk(spindle_out.cool_on, 1);
        repeat (40) @(posedge clock);
        chk(spindle_out.cool_on, 0);
        acc(1, A_FLUCT, 10); acc(1, A_MEAS, 500); acc(1, A_CMD, C_THREAD);
        rd(A_STAT, 32'h18, {27'h0, 1'b1, 16'd500 > r, 3'h0});
        acc(1, A_MEAS, 520); acc(1, A_CMD, C_BLKEND); settle;
        chk(thread_alarm, 1);
        acc(1, A_CMD, C_CYCLE); settle;
        chk(thread_alarm, 0);
        $display("test pulse and thread done");
        // Each kick may wait behind a running calculation, hence the long pauses
        acc(1, A_CFG, 8'h40); acc(1, A_GMAX1, 1000); acc(1, A_SPEED, 500);
        repeat (200) @(negedge clock);
        chk(analog_code, 500 * DAC_FULL / 1000);
        acc(1, A_SURF, 100); acc(1, A_DIAM, -50000); acc(1, A_CTRL, 1);
        repeat (250) @(negedge clock);
        rd(A_RESULT, 32'hFFFF, 32'(100 * CSS_SCALE / 50000));
        acc(1, A_CSS_MAX, 600); repeat (250) @(negedge clock);
        rd(A_RESULT, 32'hFFFF, 600);
        acc(1, A_CSS_MAX, 16'hFFFF); acc(1, A_CSS_MIN, 700); repeat (250) @(negedge clock);
        rd(A_RESULT, 32'hFFFF, 700);
        chk(analog_code, 700 * DAC_FULL / 1000);
        acc(1, A_JOG_T, 30); acc(1, A_JOG_S, 300); acc(1, A_CMD, C_JOG);
        repeat (180) @(negedge clock);
        chk(analog_code, 300 * DAC_FULL / 1000);
        rd(A_STAT, 32'h81, 32'h81);
        repeat (150) @(negedge clock);
        rd(A_STAT, 32'h81, 0);
        acc(1, A_STAT, 32'h200); acc(1, A_CMD, 32'h26);
        rd(A_STAT, 32'hF200, 32'h2000);
        $display("test converter done");
        wrap_up;
    end
endmodule
`default_nettype wire
